// file: rtl/acm_pkg.sv
// constants and types for the arp cam maintenance block
package acm_pkg;
    // ****************************************
    // synchronous port opcodes
    // ****************************************
    localparam logic [3:0] OP_LOAD = 4'h1;
    localparam logic [3:0] OP_INSERT = 4'h2;
    localparam logic [3:0] OP_DELETE = 4'h6;
    localparam logic [3:0] OP_AGE = 4'h7;
    // ****************************************
    // processor port addresses
    // ****************************************
    localparam logic [4:0] HA_LOAD = 5'h01;
    localparam logic [4:0] HA_INSERT = 5'h02;
    localparam logic [4:0] HA_DELETE = 5'h06;
    localparam logic [4:0] HA_AGE = 5'h07;
    localparam logic [4:0] HA_MATCH_FLAG = 5'h09;
    localparam logic [4:0] HA_INDEX = 5'h13;
    // ****************************************
    // register fields and reset values
    // ****************************************
    localparam int IDX_FIELD_W = 26;
    localparam int NOMATCH_BIT = 30;
    localparam int MF_BIT = 1;
    localparam logic [31:0] INDEX_REG_RST = 32'h4000_0000;
    localparam int AGE_W = 4;
    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {ACM_NONE, ACM_LOAD, ACM_INSERT, ACM_DELETE, ACM_AGE} acm_kind_e;
    typedef enum logic [1:0] {ACM_H_IDLE, ACM_H_EXEC, ACM_H_ACK} acm_hstate_e;
    typedef struct packed {
        acm_kind_e kind;
        logic [31:0] data;
    } acm_cmd_s;
    typedef struct packed {
        logic [31:0] key;
        logic [31:0] eth_lo;
        logic second;
    } acm_load_s;
    typedef struct packed {
        logic valid;
        logic perm;
        logic queued;
        logic [AGE_W-1:0] stamp;
        logic [31:0] key;
        logic [47:0] eth;
    } acm_entry_s;
    typedef struct packed {
        logic sel_n;
        logic rw;
        logic [4:0] addr;
        logic [31:0] data;
    } acm_host_s;
endpackage

// file: rtl/acm_maint.sv
// arp cam entry maintenance: delete, permanent insert and manual aging
// ****************************************
// Overview of operation
// [RULE_01] controller deletes by sending key, opcode 0110b, strobe low, one cycle
// [RULE_02] delete compares key with every location and invalidates the match
// [RULE_03] sync delete drives match flag low when key matched and was removed
// [RULE_04] sync delete hit puts index on data out, valid low one cycle
// [RULE_05] host deletes by writing key to address 00110b, select and rw low
// [RULE_06] host ready rises once comparison and deletion are finished
// [RULE_07] index register 10011b holds index in 25..0, bit 30 set on no-match
// [RULE_08] match flag register at 01001b also reports the delete outcome
// [RULE_09] sync insert: two loads opcode 0001b, then opcode 0010b with upper bits
// [RULE_10] final sync insert cycle uses input 15..0, ignores 31..16
// [RULE_11] host insert: two writes to 00001b, then one write to 00010b
// [RULE_12] final host insert write uses data 15..0, discards 31..16
// [RULE_13] age command purges or queues non-permanent entries matching age counter
// [RULE_14] age commands always accepted, with or without automatic aging
// [RULE_15] sync age is opcode 0111b with strobe low, data ignored
// [RULE_16] host age is a write to 00111b, ready rises once accepted
// [RULE_17] every host access has select low, rw low write, high read
// [RULE_18] insert fills next free slot or overwrites match, marks permanent
// [RULE_19] host waits for ready before reading results or starting again
// ****************************************
`timescale 1ns/10ps
module acm_maint import acm_pkg::*; #(
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_B,
    // synchronous command port
    input wire logic INPUT_STROBE_N,
    input wire logic [3:0] OPCODE_BUS,
    input wire logic [31:0] SYNC_DIN,
    output logic MATCH_FLAG_N,
    output logic OUT_VALID_N,
    output logic [31:0] SYNC_DOUT,
    // processor port
    input wire logic HOST_SELECT_N,
    input wire logic HOST_RW,
    input wire logic [4:0] HOST_ADDR,
    input wire logic [31:0] HOST_DATA_IN,
    output logic [31:0] HOST_DATA_OUT,
    output logic HOST_DATA_OE,
    output logic HOST_ACK,
    // queue and capacity
    input wire logic AGED_QUEUE_EN,
    output logic AGED_QUEUE_NOT_EMPTY,
    output logic FULL_FLAG_N
);
    localparam int IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    // ****************************************
    // state
    // ****************************************
    acm_entry_s mem [DEPTH];
    acm_host_s h_meta, h_sync;
    acm_hstate_e hstate, next_hstate;
    acm_load_s sync_ld, host_ld;
    logic [4:0] pend_addr;
    logic [31:0] pend_data;
    logic [31:0] index_reg;
    logic match_result_flag;
    logic [31:0] rd_data;
    logic rd_cycle;
    logic [AGE_W-1:0] age_now;
    // ****************************************
    // host pins resynchronised
    // ****************************************
    // data is caught with select; the host must hold it stable while select is low
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            h_meta <= '{sel_n: 1'b1, rw: 1'b1, addr: 5'h00, data: 32'h0000_0000};
            h_sync <= '{sel_n: 1'b1, rw: 1'b1, addr: 5'h00, data: 32'h0000_0000};
        end else begin
            h_meta <= '{sel_n: HOST_SELECT_N, rw: HOST_RW, addr: HOST_ADDR, data: HOST_DATA_IN};
            h_sync <= h_meta;
        end
    end
    // ****************************************
    // command decode and arbitration
    // ****************************************
    function automatic acm_kind_e op_kind(input logic [3:0] op);
        case (op)
            // [RULE_09] sync load/insert codes
            OP_LOAD: op_kind = ACM_LOAD;
            OP_INSERT: op_kind = ACM_INSERT;
            // [RULE_01] sync delete code
            OP_DELETE: op_kind = ACM_DELETE;
            // [RULE_15] sync age code
            OP_AGE: op_kind = ACM_AGE;
            default: op_kind = ACM_NONE;
        endcase
    endfunction
    function automatic acm_kind_e addr_kind(input logic [4:0] a);
        case (a)
            // [RULE_11] host load/insert addresses
            HA_LOAD: addr_kind = ACM_LOAD;
            HA_INSERT: addr_kind = ACM_INSERT;
            // [RULE_05] host delete address
            HA_DELETE: addr_kind = ACM_DELETE;
            // [RULE_16] host age address
            HA_AGE: addr_kind = ACM_AGE;
            default: addr_kind = ACM_NONE;
        endcase
    endfunction
    // sync port wins a shared cycle; a pending host command simply waits
    wire logic sync_go = !INPUT_STROBE_N;
    wire logic host_go = (hstate == ACM_H_EXEC) && !sync_go;
    wire acm_cmd_s sync_cmd = '{kind: op_kind(OPCODE_BUS), data: SYNC_DIN};
    wire acm_cmd_s host_cmd = '{kind: addr_kind(pend_addr), data: pend_data};
    wire acm_cmd_s cmd = sync_go ? sync_cmd : (host_go ? host_cmd : acm_cmd_s'('0));
    wire acm_load_s act_ld = sync_go ? sync_ld : host_ld;
    wire logic [31:0] cmd_key = (cmd.kind == ACM_DELETE) ? cmd.data : act_ld.key;
    // [RULE_10] [RULE_12] upper half of the final word discarded
    wire logic [47:0] new_eth = {cmd.data[15:0], act_ld.eth_lo};
    // ****************************************
    // associative search
    // ****************************************
    logic hit, has_free, any_queued;
    logic [IDX_W-1:0] hit_idx, free_idx;
    always_comb begin
        hit = 1'b0;
        hit_idx = '0;
        has_free = 1'b0;
        free_idx = '0;
        any_queued = 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            // [RULE_02] key against every location
            if (mem[i].valid && (mem[i].key == cmd_key) && !hit) begin
                hit = 1'b1;
                hit_idx = IDX_W'(i);
            end
            if (!mem[i].valid && !has_free) begin
                has_free = 1'b1;
                free_idx = IDX_W'(i);
            end
            any_queued = any_queued || (mem[i].valid && mem[i].queued);
        end
    end
    wire logic [IDX_FIELD_W-1:0] hit_field = IDX_FIELD_W'(hit_idx);
    // ****************************************
    // entry array
    // ****************************************
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                // [RULE_13] purge or queue aged entries
                if ((cmd.kind == ACM_AGE) && mem[i].valid && !mem[i].perm &&
                    (mem[i].stamp == age_now)) begin
                    if (AGED_QUEUE_EN) begin
                        mem[i].queued <= 1'b1;
                    end else begin
                        mem[i].valid <= 1'b0;
                    end
                end
            end
            // [RULE_02] invalidate matching location
            if ((cmd.kind == ACM_DELETE) && hit) begin
                mem[hit_idx].valid <= 1'b0;
            end
            // [RULE_18] overwrite match or fill free slot
            if ((cmd.kind == ACM_INSERT) && hit) begin
                mem[hit_idx].eth <= new_eth;
                mem[hit_idx].perm <= 1'b1;
                mem[hit_idx].queued <= 1'b0;
            end else if ((cmd.kind == ACM_INSERT) && has_free) begin
                mem[free_idx] <= '{valid: 1'b1, perm: 1'b1, queued: 1'b0, stamp: age_now,
                                   key: act_ld.key, eth: new_eth};
            end
        end
    end
    // ****************************************
    // load staging and age counter
    // ****************************************
    function automatic acm_load_s next_load(input acm_load_s ld, input acm_kind_e k,
                                            input logic [31:0] d);
        next_load = ld;
        // [RULE_09] first word key, second word low address bits
        if (k == ACM_LOAD) begin
            if (!ld.second) begin
                next_load.key = d;
            end else begin
                next_load.eth_lo = d;
            end
            next_load.second = !ld.second;
        end else if (k == ACM_INSERT) begin
            next_load.second = 1'b0;
        end
    endfunction
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            sync_ld <= '0;
            host_ld <= '0;
            age_now <= '0;
        end else begin
            if (sync_go) begin
                sync_ld <= next_load(sync_ld, cmd.kind, cmd.data);
            end
            // [RULE_11] host loads staged apart from sync loads
            if (host_go) begin
                host_ld <= next_load(host_ld, cmd.kind, cmd.data);
            end
            // [RULE_14] accepted regardless of auto-aging
            if (cmd.kind == ACM_AGE) begin
                age_now <= age_now + 1'b1;
            end
        end
    end
    // ****************************************
    // synchronous port results
    // ****************************************
    wire logic sync_del = sync_go && (cmd.kind == ACM_DELETE);
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            MATCH_FLAG_N <= 1'b1;
            OUT_VALID_N <= 1'b1;
            SYNC_DOUT <= 32'h0000_0000;
        end else begin
            // [RULE_04] one-cycle valid strobe with index
            OUT_VALID_N <= !(sync_del && hit);
            if (sync_del) begin
                // [RULE_03] low flag marks a removed match
                MATCH_FLAG_N <= !hit;
                if (hit) begin
                    SYNC_DOUT <= 32'(hit_idx);
                end
            end
        end
    end
    // ****************************************
    // processor port sequencer
    // ****************************************
    wire logic host_start = (hstate == ACM_H_IDLE) && !h_sync.sel_n;
    wire logic host_rd = host_start && h_sync.rw;
    wire logic [31:0] rd_mux = (h_sync.addr == HA_INDEX) ? index_reg :
                               (h_sync.addr == HA_MATCH_FLAG) ?
                               (32'(match_result_flag) << MF_BIT) : 32'h0000_0000;
    always_comb begin
        next_hstate = hstate;
        case (hstate)
            // [RULE_17] rw low writes, rw high reads
            ACM_H_IDLE: begin
                if (!h_sync.sel_n) begin
                    next_hstate = h_sync.rw ? ACM_H_ACK : ACM_H_EXEC;
                end
            end
            ACM_H_EXEC: begin
                if (host_go) begin
                    next_hstate = ACM_H_ACK;
                end
            end
            // [RULE_19] ready held until the host releases select
            ACM_H_ACK: begin
                if (h_sync.sel_n) begin
                    next_hstate = ACM_H_IDLE;
                end
            end
            default: next_hstate = ACM_H_IDLE;
        endcase
    end
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            hstate <= ACM_H_IDLE;
            pend_addr <= 5'h00;
            pend_data <= 32'h0000_0000;
            rd_data <= 32'h0000_0000;
            rd_cycle <= 1'b0;
            index_reg <= INDEX_REG_RST;
            match_result_flag <= 1'b0;
        end else begin
            hstate <= next_hstate;
            if (host_start) begin
                pend_addr <= h_sync.addr;
                pend_data <= h_sync.data;
                rd_cycle <= h_sync.rw;
            end
            rd_data <= host_rd ? rd_mux : rd_data;
            // [RULE_07] index in low field, bit 30 no-match
            if (host_go && (cmd.kind == ACM_DELETE)) begin
                index_reg <= (32'(!hit) << NOMATCH_BIT) | 32'(hit_field);
                // [RULE_08] flag register mirrors outcome
                match_result_flag <= hit;
            end
        end
    end
    // ****************************************
    // outputs
    // ****************************************
    // [RULE_06] ready only after the command has run
    assign HOST_ACK = (hstate == ACM_H_ACK);
    assign HOST_DATA_OE = HOST_ACK && rd_cycle;
    assign HOST_DATA_OUT = rd_data;
    assign AGED_QUEUE_NOT_EMPTY = any_queued;
    assign FULL_FLAG_N = has_free;
endmodule // acm_maint

// file: verif/acm_maint_asserts.sv
// port assertions for the arp cam maintenance block
`timescale 1ns/10ps
module acm_maint_chk import acm_pkg::*; (
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_B,
    // synchronous port
    input wire logic INPUT_STROBE_N,
    input wire logic [3:0] OPCODE_BUS,
    input wire logic MATCH_FLAG_N,
    input wire logic OUT_VALID_N,
    // processor port
    input wire logic HOST_SELECT_N,
    input wire logic HOST_RW,
    input wire logic HOST_DATA_OE,
    input wire logic HOST_ACK
);
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    wire logic del = !INPUT_STROBE_N && OPCODE_BUS == OP_DELETE;
    AST_PULSE_ONE: assert property ($fell(OUT_VALID_N) |=> OUT_VALID_N)
        else $error("valid pulse longer than one cycle");
    AST_PULSE_CAUSE: assert property ($fell(OUT_VALID_N) |-> $past(del))
        else $error("valid pulse without a delete");
    AST_HIT_FLAG: assert property (del |=> MATCH_FLAG_N == OUT_VALID_N)
        else $error("match flag and valid disagree after delete");
    AST_FLAG_HOLD: assert property (!del |=> $stable(MATCH_FLAG_N))
        else $error("match flag moved without a delete");
    AST_ACK_SEL: assert property (
        $rose(HOST_ACK) |-> !HOST_SELECT_N && !$past(HOST_SELECT_N, 2))
        else $error("ready without a selected access");
    AST_ACK_BOUND: assert property ($fell(HOST_SELECT_N) |-> ##[2:12] HOST_ACK)
        else $error("ready late");
    AST_ACK_HOLD: assert property (HOST_ACK && !HOST_SELECT_N |=> HOST_ACK)
        else $error("ready dropped while selected");
    AST_ACK_DROP: assert property ($rose(HOST_SELECT_N) |-> ##[1:4] !HOST_ACK)
        else $error("ready stuck after deselect");
    AST_OE_READ: assert property (HOST_DATA_OE |-> HOST_ACK && HOST_RW)
        else $error("bus driven outside a read");
    AST_OE_READ_ON: assert property (HOST_ACK && HOST_RW |-> HOST_DATA_OE)
        else $error("read data not driven while ready");
endmodule // acm_maint_chk
bind acm_maint acm_maint_chk u_chk (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
    .INPUT_STROBE_N(INPUT_STROBE_N), .OPCODE_BUS(OPCODE_BUS), .MATCH_FLAG_N(MATCH_FLAG_N),
    .OUT_VALID_N(OUT_VALID_N), .HOST_SELECT_N(HOST_SELECT_N), .HOST_RW(HOST_RW),
    .HOST_DATA_OE(HOST_DATA_OE), .HOST_ACK(HOST_ACK));

// file: verif/acm_host_model.sv
// host processor model driving the processor port
`timescale 1ns/10ps
module acm_host_model (
    // clock
    input wire logic SYS_CLK,
    // processor port
    output logic HOST_SELECT_N = 1'b1,
    output logic HOST_RW = 1'b1,
    output logic [4:0] HOST_ADDR = 5'h00,
    output logic [31:0] HOST_DATA_IN = 32'h0,
    input wire logic [31:0] HOST_DATA_OUT,
    input wire logic HOST_ACK,
    // status
    output logic TIMED_OUT = 1'b0
);
    // ****************************************
    // one access
    // ****************************************
    // select low, rw low write, high read
    task automatic access(input logic rw, input logic [4:0] a, input logic [31:0] d,
                          output logic [31:0] q);
        int n;
        n = 0;
        @(posedge SYS_CLK);
        HOST_SELECT_N <= 1'b0;
        HOST_RW <= rw;
        HOST_ADDR <= a;
        HOST_DATA_IN <= d;
        while (HOST_ACK !== 1'b1 && n < 40) begin
            @(posedge SYS_CLK);
            n++;
        end
        q = HOST_DATA_OUT;
        HOST_SELECT_N <= 1'b0 ^ 1'b1;
        // released data shows the inverse so stale values cannot pass
        HOST_DATA_IN <= ~d;
        while (HOST_ACK !== 1'b0 && n < 40) begin
            @(posedge SYS_CLK);
            n++;
        end
        if (n >= 40) TIMED_OUT = 1'b1;
    endtask
endmodule // acm_host_model

// file: verif/tb_top.sv
// self-checking bench for the arp cam maintenance block
`timescale 1ns/10ps
module tb_top;
    import acm_pkg::*;
    localparam int DEPTH = 4;
    logic SYS_CLK = 1'b0;
    logic RST_B = 1'b0;
    logic INPUT_STROBE_N = 1'b1;
    logic [3:0] OPCODE_BUS = 4'h0;
    logic [31:0] SYNC_DIN = 32'h0;
    logic AGED_QUEUE_EN = 1'b0;
    wire logic MATCH_FLAG_N, OUT_VALID_N, HOST_SELECT_N, HOST_RW, HOST_DATA_OE, HOST_ACK;
    wire logic AGED_QUEUE_NOT_EMPTY, FULL_FLAG_N, TIMED_OUT;
    wire logic [31:0] SYNC_DOUT, HOST_DATA_OUT, HOST_DATA_IN;
    wire logic [4:0] HOST_ADDR;
    int n_mismatch = 0;
    int n_tests = 0;
    logic [31:0] seed = 32'h12;
    logic [31:0] mkey [DEPTH];
    bit mval [DEPTH];
    logic [31:0] kk [5];
    logic [31:0] q;
    always #25 SYS_CLK = ~SYS_CLK;
    acm_maint #(.DEPTH(DEPTH)) DUT (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
        .INPUT_STROBE_N(INPUT_STROBE_N), .OPCODE_BUS(OPCODE_BUS), .SYNC_DIN(SYNC_DIN),
        .MATCH_FLAG_N(MATCH_FLAG_N), .OUT_VALID_N(OUT_VALID_N), .SYNC_DOUT(SYNC_DOUT),
        .HOST_SELECT_N(HOST_SELECT_N), .HOST_RW(HOST_RW), .HOST_ADDR(HOST_ADDR),
        .HOST_DATA_IN(HOST_DATA_IN), .HOST_DATA_OUT(HOST_DATA_OUT),
        .HOST_DATA_OE(HOST_DATA_OE), .HOST_ACK(HOST_ACK), .AGED_QUEUE_EN(AGED_QUEUE_EN),
        .AGED_QUEUE_NOT_EMPTY(AGED_QUEUE_NOT_EMPTY), .FULL_FLAG_N(FULL_FLAG_N));
    acm_host_model HOST (.SYS_CLK(SYS_CLK), .HOST_SELECT_N(HOST_SELECT_N),
        .HOST_RW(HOST_RW), .HOST_ADDR(HOST_ADDR), .HOST_DATA_IN(HOST_DATA_IN),
        .HOST_DATA_OUT(HOST_DATA_OUT), .HOST_ACK(HOST_ACK), .TIMED_OUT(TIMED_OUT));
    // ****************************************
    // model, drivers and checks
    // ****************************************
    function automatic void nxt();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    function automatic int m_find(input logic [31:0] k);
        for (int i = 0; i < DEPTH; i++) if (mval[i] && mkey[i] === k) return i;
        return -1;
    endfunction
    // overwrite a match, else lowest free slot, dropped when full
    function automatic void m_insert(input logic [31:0] k);
        int i;
        i = m_find(k);
        if (i < 0) for (int j = DEPTH - 1; j >= 0; j--) if (!mval[j]) i = j;
        if (i >= 0) mval[i] = 1;
        if (i >= 0) mkey[i] = k;
    endfunction
    task automatic scmd(input logic [3:0] op, input logic [31:0] d);
        INPUT_STROBE_N <= 1'b0;
        OPCODE_BUS <= op;
        SYNC_DIN <= d;
        @(posedge SYS_CLK);
    endtask
    task automatic hacc(input logic rw, input logic [4:0] a, input logic [31:0] d);
        HOST.access(rw, a, d, q);
        if (TIMED_OUT === 1'b1) begin
            n_mismatch++;
            summarize();
        end
    endtask
    // three-step insert, upper half is junk
    task automatic ins(input bit host, input logic [31:0] k);
        nxt();
        if (host) begin
            hacc(1'b0, HA_LOAD, k);
            hacc(1'b0, HA_LOAD, seed);
            hacc(1'b0, HA_INSERT, {~seed[31:16], seed[15:0]});
        end else begin
            scmd(OP_LOAD, k);
            scmd(OP_LOAD, seed);
            scmd(OP_INSERT, {~seed[31:16], seed[15:0]});
            INPUT_STROBE_N <= 1'b1;
            @(posedge SYS_CLK);
        end
        m_insert(k);
    endtask
    // delete by key on either port
    task automatic del(input bit host, input logic [31:0] k);
        int i;
        i = m_find(k);
        if (host) begin
            hacc(1'b0, HA_DELETE, k);
            hacc(1'b1, HA_INDEX, seed);
            check("idx_miss", q[30], i < 0);
            if (i >= 0) check("idx", q[25:0], 32'(i));
            hacc(1'b1, HA_MATCH_FLAG, seed);
            check("mf_reg", q[MF_BIT], i >= 0);
        end else begin
            scmd(OP_DELETE, k);
            INPUT_STROBE_N <= 1'b1;
            @(negedge SYS_CLK);
            check("mf_pin", MATCH_FLAG_N, i < 0);
            check("valid", OUT_VALID_N, i < 0);
            if (i >= 0) check("dout", SYNC_DOUT, 32'(i));
            @(negedge SYS_CLK);
            check("pulse", OUT_VALID_N, 1'b1);
            @(posedge SYS_CLK);
        end
        if (i >= 0) mval[i] = 0;
    endtask
    initial begin
        repeat (10) @(posedge SYS_CLK);
        RST_B <= 1'b1;
        @(posedge SYS_CLK);
        hacc(1'b1, HA_INDEX, 32'h0);
        check("idx_rst", q, INDEX_REG_RST);
        for (int n = 0; n < 5; n++) begin
            nxt();
            kk[n] = seed;
        end
        // mixed ports, a repeated key, then one insert too many
        ins(0, kk[0]);
        ins(1, kk[1]);
        ins(0, kk[0]);
        ins(0, kk[2]);
        ins(1, kk[3]);
        ins(0, kk[4]);
        check("full", FULL_FLAG_N, 1'b0);
        // age on both ports
        // permanent entries must survive aging in both queue modes
        scmd(OP_AGE, seed);
        INPUT_STROBE_N <= 1'b1;
        AGED_QUEUE_EN <= 1'b1;
        hacc(1'b0, HA_AGE, ~seed);
        check("queue", AGED_QUEUE_NOT_EMPTY, 1'b0);
        check("kept", FULL_FLAG_N, 1'b0);
        del(0, kk[4]);
        del(0, kk[2]);
        del(1, kk[1]);
        del(1, kk[4]);
        del(0, kk[3]);
        check("not_full", FULL_FLAG_N, 1'b1);
        hacc(1'b1, 5'h1F, 32'h0);
        check("unmapped", q, 32'h0);
        ins(1, kk[4]);
        del(0, kk[4]);
        del(1, kk[0]);
        del(0, kk[0]);
        summarize();
    end
endmodule // tb_top
